// ==== design/lcsd_params.svh ====
`ifndef LCSD_PARAMS_SVH
`define LCSD_PARAMS_SVH
// Bank count, bank bit positions on the rising-edge field and the auto-close bit on the falling-edge field
`define LCSD_NBANK 4
`define LCSD_BANK_LO_POS 7
`define LCSD_BANK_HI_POS 8
`define LCSD_AUTO_CLOSE_POS 0
// Timing figures in ns and the cycle counts derived at 5 ns per cycle
`define LCSD_CLK_NS 5
`define LCSD_ROW_PRECHARGE_NS 18
`define LCSD_ROW_TO_COLUMN_NS 18
`define LCSD_REFRESH_CYCLE_NS 90
`define LCSD_MODE_READ_NS 10
`define LCSD_MODE_WRITE_NS 10
`define LCSD_BURST_NS 20
`define LCSD_CYC_UP(ns) (((ns) + `LCSD_CLK_NS - 1) / `LCSD_CLK_NS)
`define LCSD_RP_CYC `LCSD_CYC_UP(`LCSD_ROW_PRECHARGE_NS)
`define LCSD_RCD_CYC `LCSD_CYC_UP(`LCSD_ROW_TO_COLUMN_NS)
`define LCSD_RFC_CYC `LCSD_CYC_UP(`LCSD_REFRESH_CYCLE_NS)
`define LCSD_MRR_CYC `LCSD_CYC_UP(`LCSD_MODE_READ_NS)
`define LCSD_MRW_CYC `LCSD_CYC_UP(`LCSD_MODE_WRITE_NS)
`define LCSD_BURST_CYC `LCSD_CYC_UP(`LCSD_BURST_NS)
`endif

// ==== design/lcsd_pkg.sv ====
package lcsd_pkg;
	typedef enum logic [8:0] {
		BK_IDLE = 9'h001, BK_ACTIVATING = 9'h002, BK_ACTIVE = 9'h004,
		BK_READING = 9'h008, BK_WRITING = 9'h010, BK_PRECHARGING = 9'h020,
		BK_RD_CLOSE = 9'h040, BK_WR_CLOSE = 9'h080, BK_SPARE = 9'h100
	} lcsd_bank_t;
	typedef enum logic [9:0] {
		DV_NORMAL = 10'h001, DV_REFRESHING = 10'h002, DV_MODE_READ = 10'h004,
		DV_MODE_WRITE = 10'h008, DV_RESETTING = 10'h010, DV_POWER_DOWN = 10'h020,
		DV_SELF_REFRESH = 10'h040, DV_DEEPEST_SLEEP = 10'h080, DV_POWER_ON = 10'h100,
		DV_RESET_DOWN = 10'h200
	} lcsd_dev_t;
	typedef enum logic [3:0] {
		CM_NOP = 4'h0, CM_MODE_WRITE = 4'h1, CM_MODE_READ = 4'h2, CM_REFRESH = 4'h3,
		CM_SELF_REFRESH = 4'h4, CM_ACTIVATE = 4'h5, CM_WRITE = 4'h6, CM_READ = 4'h7,
		CM_PRECHARGE = 4'h8, CM_BURST_STOP = 4'h9, CM_DEEPEST = 4'ha, CM_POWER_DOWN = 4'hb,
		CM_EXIT = 4'hc, CM_HOLD = 4'hd, CM_BAD = 4'he
	} lcsd_cmd_t;
endpackage : lcsd_pkg

// ==== design/lcsd_ca_capture.sv ====
// Samples the link clock and the command pins; all pins pass two flops first.
module lcsd_ca_capture
	import lcsd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic chipSel_n,
	input wire logic clkEnable,
	input wire logic [9:0] cmd_addr_bus,
	output logic cmdValid,
	output logic riseCs_n,
	output logic riseCke,
	output logic prevCke,
	output logic [9:0] riseCa,
	output logic [9:0] fallCa
);
	logic [1:0] clkSync;
	logic [1:0] csSync;
	logic [1:0] ckeSync;
	logic [9:0] caSync0;
	logic [9:0] caSync1;
	logic clkLast;
	logic havePending;
	logic next_cmdValid;
	logic next_riseCs_n;
	logic next_riseCke;
	logic next_prevCke;
	logic next_havePending;
	logic [9:0] next_riseCa;
	logic [9:0] next_fallCa;
	logic riseEdge;
	logic fallEdge;

	assign riseEdge = clkSync[1] & ~clkLast;
	assign fallEdge = ~clkSync[1] & clkLast;

	// Rising edge latches pins; falling edge completes the command
	always_comb begin
		next_cmdValid = 1'b0;
		next_riseCs_n = riseCs_n;
		next_riseCke = riseCke;
		next_prevCke = prevCke;
		next_riseCa = riseCa;
		next_fallCa = fallCa;
		next_havePending = havePending;
		if (riseEdge) begin
			next_prevCke = riseCke;
			next_riseCke = ckeSync[1];
			next_riseCs_n = csSync[1];
			next_riseCa = caSync1;
			next_havePending = 1'b1;
		end else if (fallEdge && havePending) begin
			next_fallCa = caSync1;
			next_havePending = 1'b0;
			next_cmdValid = 1'b1;
		end
	end

	// Pin synchronisers: every pin sees matched delay so edges stay aligned
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clkSync <= 2'h0;
			csSync <= 2'h3;
			ckeSync <= 2'h0;
			caSync0 <= 10'h000;
			caSync1 <= 10'h000;
			clkLast <= 1'b0;
			havePending <= 1'b0;
			cmdValid <= 1'b0;
			riseCs_n <= 1'b1;
			riseCke <= 1'b0;
			prevCke <= 1'b0;
			riseCa <= 10'h000;
			fallCa <= 10'h000;
		end else begin
			clkSync <= {clkSync[0], linkClk};
			csSync <= {csSync[0], chipSel_n};
			ckeSync <= {ckeSync[0], clkEnable};
			caSync0 <= cmd_addr_bus;
			caSync1 <= caSync0;
			clkLast <= clkSync[1];
			havePending <= next_havePending;
			cmdValid <= next_cmdValid;
			riseCs_n <= next_riseCs_n;
			riseCke <= next_riseCke;
			prevCke <= next_prevCke;
			riseCa <= next_riseCa;
			fallCa <= next_fallCa;
		end
	end
endmodule : lcsd_ca_capture

// ==== design/lpddr_cmd_state_decoder.sv ====
module lpddr_cmd_state_decoder
	import lcsd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic chipSel_n,
	input wire logic clkEnable,
	input wire logic [9:0] cmd_addr_bus,
	input wire logic initDone,
	output logic [35:0] bankStates,
	output logic [9:0] devState,
	output logic [51:0] openRows,
	output logic [1:0] lastBank,
	output logic [7:0] lastColumn,
	output logic [3:0] lastCmd,
	output logic illegalCmd
);
`include "lcsd_params.svh"

	logic cmdValid;
	logic riseCs_n;
	logic riseCke;
	logic prevCke;
	logic [9:0] riseCa;
	logic [9:0] fallCa;
	lcsd_bank_t bank [`LCSD_NBANK];
	lcsd_bank_t next_bank [`LCSD_NBANK];
	logic [7:0] bankTimer [`LCSD_NBANK];
	logic [7:0] next_bankTimer [`LCSD_NBANK];
	logic [12:0] rowReg [`LCSD_NBANK];
	logic [12:0] next_rowReg [`LCSD_NBANK];
	lcsd_dev_t dev;
	lcsd_dev_t next_dev;
	logic [7:0] devTimer;
	logic [7:0] next_devTimer;
	logic [1:0] burstBank;
	logic [1:0] next_burstBank;
	logic [7:0] next_lastColumn;
	logic [3:0] next_lastCmd;
	logic next_illegalCmd;
	lcsd_cmd_t cmd;
	logic [1:0] selBank;
	logic allIdle;
	logic [1:0] pinSync;
	logic exitReq;

	lcsd_ca_capture capture (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.linkClk(linkClk),
		.chipSel_n(chipSel_n),
		.clkEnable(clkEnable),
		.cmd_addr_bus(cmd_addr_bus),
		.cmdValid(cmdValid),
		.riseCs_n(riseCs_n),
		.riseCke(riseCke),
		.prevCke(prevCke),
		.riseCa(riseCa),
		.fallCa(fallCa)
	);

	// Command identity from select, enable pair and the first four CA bits
	function automatic lcsd_cmd_t decode(input logic cs_n, input logic ckeP,
		input logic ckeN, input logic [3:0] ca);
		decode = CM_BAD;
		if (!ckeP && !ckeN) begin
			decode = CM_HOLD;
		end else if (!ckeP && ckeN) begin
			decode = cs_n ? CM_EXIT : CM_BAD;
		end else if (cs_n) begin
			decode = ckeN ? CM_NOP : CM_POWER_DOWN;
		end else if (!ckeN) begin
			if (ca[2:0] == 3'h4) begin
				decode = CM_SELF_REFRESH;
			end else if (ca[2:0] == 3'h3) begin
				decode = CM_DEEPEST;
			end
		end else begin
			case (ca)
				4'h0: decode = CM_MODE_WRITE;
				4'h8: decode = CM_MODE_READ;
				4'h4, 4'hc: decode = CM_REFRESH;
				4'h2, 4'ha, 4'h6, 4'he: decode = CM_ACTIVATE;
				4'h1, 4'h9: decode = CM_WRITE;
				4'h5, 4'hd: decode = CM_READ;
				4'hb: decode = CM_PRECHARGE;
				4'h3: decode = CM_BURST_STOP;
				4'h7, 4'hf: decode = CM_NOP;
				default: decode = CM_BAD;
			endcase
		end
	endfunction : decode

	assign cmd = decode(riseCs_n, prevCke, riseCke, riseCa[3:0]);
	assign selBank = {riseCa[`LCSD_BANK_HI_POS], riseCa[`LCSD_BANK_LO_POS]};

	// All banks settled idle; refresh and mode write are refused otherwise
	always_comb begin
		allIdle = 1'b1;
		for (int i = 0; i < `LCSD_NBANK; i++) begin
			if (bank[i] != BK_IDLE) begin
				allIdle = 1'b0;
			end
		end
	end

	// Exit from the deepest states needs no link clock edge: enable is watched directly
	assign exitReq = pinSync[1];

	// Bank and device state update; timers count down to the settled state
	always_comb begin
		next_dev = dev;
		next_devTimer = (devTimer != 8'h00) ? devTimer - 8'h01 : 8'h00;
		next_burstBank = burstBank;
		next_lastColumn = lastColumn;
		next_lastCmd = lastCmd;
		next_illegalCmd = 1'b0;
		for (int i = 0; i < `LCSD_NBANK; i++) begin
			next_bank[i] = bank[i];
			next_rowReg[i] = rowReg[i];
			next_bankTimer[i] = (bankTimer[i] != 8'h00) ? bankTimer[i] - 8'h01 : 8'h00;
			if (bankTimer[i] == 8'h01) begin
				case (bank[i])
					BK_ACTIVATING: next_bank[i] = BK_ACTIVE;
					BK_READING, BK_WRITING: next_bank[i] = BK_ACTIVE;
					BK_RD_CLOSE, BK_WR_CLOSE: begin
						next_bank[i] = BK_PRECHARGING;
						next_bankTimer[i] = 8'(`LCSD_RP_CYC);
					end
					BK_PRECHARGING: next_bank[i] = BK_IDLE;
					default: next_bank[i] = bank[i];
				endcase
			end
		end
		if (devTimer == 8'h01) begin
			case (dev)
				DV_REFRESHING, DV_MODE_WRITE: next_dev = DV_NORMAL;
				DV_MODE_READ: next_dev = DV_NORMAL;
				default: next_dev = dev;
			endcase
		end
		if ((dev == DV_SELF_REFRESH || dev == DV_DEEPEST_SLEEP) && exitReq) begin
			next_dev = (dev == DV_SELF_REFRESH) ? DV_NORMAL : DV_POWER_ON;
		end else if (cmdValid) begin
			next_lastCmd = cmd;
			case (cmd)
				CM_HOLD: next_dev = dev;
				CM_EXIT: begin
					if (dev == DV_POWER_DOWN) begin
						next_dev = DV_NORMAL;
					end else if (dev == DV_RESET_DOWN) begin
						next_dev = initDone ? DV_NORMAL : DV_RESETTING;
					end
				end
				CM_POWER_DOWN: begin
					if (dev == DV_RESETTING) begin
						next_dev = DV_RESET_DOWN;
					end else if (dev == DV_NORMAL) begin
						next_dev = DV_POWER_DOWN;
					end
				end
				CM_SELF_REFRESH: next_dev = DV_SELF_REFRESH;
				CM_DEEPEST: next_dev = DV_DEEPEST_SLEEP;
				// Refused with a bank open, so no open row is silently lost
				CM_REFRESH: begin
					if (allIdle) begin
						next_dev = DV_REFRESHING;
						next_devTimer = 8'(`LCSD_RFC_CYC);
					end else begin
						next_illegalCmd = 1'b1;
					end
				end
				CM_MODE_WRITE: begin
					if (allIdle) begin
						next_dev = (dev == DV_POWER_ON) ? DV_RESETTING : DV_MODE_WRITE;
						next_devTimer = (dev == DV_POWER_ON) ? 8'h00 : 8'(`LCSD_MRW_CYC);
					end else begin
						next_illegalCmd = 1'b1;
					end
				end
				CM_MODE_READ: begin
					next_dev = (dev == DV_RESETTING) ? DV_RESETTING : DV_MODE_READ;
					next_devTimer = 8'(`LCSD_MRR_CYC);
				end
				CM_ACTIVATE: begin
					next_bank[selBank] = BK_ACTIVATING;
					next_bankTimer[selBank] = 8'(`LCSD_RCD_CYC);
					next_rowReg[selBank] = {riseCa[6:2], fallCa[7:0]};
				end
				CM_READ, CM_WRITE: begin
					next_lastColumn = {fallCa[5:1], riseCa[6:5], 1'b0};
					next_burstBank = selBank;
					next_bankTimer[selBank] = 8'(`LCSD_BURST_CYC);
					if (cmd == CM_READ) begin
						next_bank[selBank] = fallCa[`LCSD_AUTO_CLOSE_POS] ? BK_RD_CLOSE : BK_READING;
					end else begin
						next_bank[selBank] = fallCa[`LCSD_AUTO_CLOSE_POS] ? BK_WR_CLOSE : BK_WRITING;
					end
				end
				CM_BURST_STOP: begin
					if (bank[burstBank] == BK_READING || bank[burstBank] == BK_WRITING) begin
						next_bank[burstBank] = BK_ACTIVE;
						next_bankTimer[burstBank] = 8'h00;
					end else begin
						next_illegalCmd = 1'b1;
					end
				end
				CM_PRECHARGE: begin
					for (int i = 0; i < `LCSD_NBANK; i++) begin
						if (riseCa[4] || selBank == 2'(i)) begin
							next_bank[i] = BK_PRECHARGING;
							next_bankTimer[i] = 8'(`LCSD_RP_CYC);
						end
					end
				end
				CM_BAD: next_illegalCmd = 1'b1;
				default: next_dev = dev;
			endcase
		end
	end

	// Outputs flattened for observation; low bank in the low bits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinSync <= 2'h0;
			dev <= DV_POWER_ON;
			devTimer <= 8'h00;
			burstBank <= 2'h0;
			lastColumn <= 8'h00;
			lastCmd <= 4'h0;
			illegalCmd <= 1'b0;
			devState <= 10'h100;
			bankStates <= 36'h0;
			openRows <= 52'h0;
			lastBank <= 2'h0;
			for (int i = 0; i < `LCSD_NBANK; i++) begin
				bank[i] <= BK_IDLE;
				bankTimer[i] <= 8'h00;
				rowReg[i] <= 13'h0000;
			end
		end else begin
			pinSync <= {pinSync[0], clkEnable};
			dev <= next_dev;
			devTimer <= next_devTimer;
			burstBank <= next_burstBank;
			lastColumn <= next_lastColumn;
			lastCmd <= next_lastCmd;
			illegalCmd <= next_illegalCmd;
			devState <= next_dev;
			lastBank <= next_burstBank;
			for (int i = 0; i < `LCSD_NBANK; i++) begin
				bank[i] <= next_bank[i];
				bankTimer[i] <= next_bankTimer[i];
				rowReg[i] <= next_rowReg[i];
				bankStates[i*9 +: 9] <= next_bank[i];
				openRows[i*13 +: 13] <= next_rowReg[i];
			end
		end
	end
endmodule : lpddr_cmd_state_decoder

// ==== sim/lcsd_properties.sv ====
module lcsd_properties
	import lcsd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEnable,
	input wire logic [35:0] bankStates,
	input wire logic [9:0] devState,
	input wire logic [7:0] lastColumn,
	input wire logic [3:0] lastCmd,
	input wire logic illegalCmd
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// States that must not move while enable stays low
	logic lowPower;
	assign lowPower = devState inside {DV_POWER_DOWN, DV_SELF_REFRESH, DV_DEEPEST_SLEEP, DV_RESET_DOWN};

	a_column_zero: assert property (lastColumn[0] == 1'b0)
		else $error("column bit zero is not zero");
	a_column_cause: assert property ($changed(lastColumn) |-> lastCmd inside {CM_READ, CM_WRITE})
		else $error("column moved without a read or write");
	a_hold_low: assert property ((!clkEnable)[*8] ##0 lowPower |=> $stable(devState))
		else $error("low-power state moved with enable low");
	a_sr_exit: assert property ($rose(clkEnable) && devState == DV_SELF_REFRESH
		|-> ##[1:6] devState == DV_NORMAL) else $error("self refresh exit late");
	a_dpd_exit: assert property ($rose(clkEnable) && devState == DV_DEEPEST_SLEEP
		|-> ##[1:6] devState == DV_POWER_ON) else $error("deepest sleep exit late");
	a_illegal_pulse: assert property (illegalCmd |=> !illegalCmd)
		else $error("refusal pulse too long");
	a_refuse_stable: assert property (illegalCmd |-> $stable(bankStates) && $stable(devState))
		else $error("refused command changed state");
	// Rise of bank 0 precharging must last the full row precharge, 4 cycles at 5 ns
	a_precharge_hold: assert property ($rose(bankStates[5]) |-> bankStates[5][*4])
		else $error("precharge ended early");
	a_onehot_states: assert property ($onehot(devState) && $onehot0(bankStates[8:0])
		&& $onehot0(bankStates[17:9]) && $onehot0(bankStates[26:18])
		&& $onehot0(bankStates[35:27])) else $error("state encoding broken");
endmodule : lcsd_properties

bind lpddr_cmd_state_decoder lcsd_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.clkEnable(clkEnable), .bankStates(bankStates), .devState(devState),
	.lastColumn(lastColumn), .lastCmd(lastCmd), .illegalCmd(illegalCmd));

// ==== sim/lcsd_ctl_model.sv ====
// Memory controller side: one command per link period, clock still between commands
module lcsd_ctl_model (
	output logic linkClk,
	output logic chipSel_n,
	output logic clkEnable,
	output logic [9:0] cmd_addr_bus
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		linkClk = 1'b0;
		chipSel_n = 1'b1;
		clkEnable = 1'b1;
		cmd_addr_bus = 10'h000;
	end
	// Rising half then falling half, each set up 40 ns ahead of its edge
	task automatic cmd(input logic csn, input logic cke, input logic [9:0] r, input logic [9:0] f);
		chipSel_n = csn;
		clkEnable = cke;
		cmd_addr_bus = r;
		#40 linkClk = 1'b1;
		#40 cmd_addr_bus = f;
		#40 linkClk = 1'b0;
		#40;
	endtask : cmd
	// Enable change with no link edge, for the asynchronous wake-ups
	task automatic setCke(input logic v);
		clkEnable = v;
	endtask : setCke
endmodule : lcsd_ctl_model

// ==== sim/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lcsd_pkg::*;
	logic ref_clk, rst_n, initDone, linkClk, chipSel_n, clkEnable, illegalCmd, sawIllegal, ap;
	logic [9:0] cmd_addr_bus, devState, r, f;
	logic [35:0] bankStates;
	logic [51:0] openRows;
	logic [1:0] lastBank, b;
	logic [7:0] lastColumn;
	logic [3:0] lastCmd, op;
	lcsd_bank_t expSt [4];
	int errors, checks_done;

	lpddr_cmd_state_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .linkClk(linkClk),
		.chipSel_n(chipSel_n), .clkEnable(clkEnable), .cmd_addr_bus(cmd_addr_bus),
		.initDone(initDone), .bankStates(bankStates), .devState(devState), .openRows(openRows),
		.lastBank(lastBank), .lastColumn(lastColumn), .lastCmd(lastCmd), .illegalCmd(illegalCmd));
	lcsd_ctl_model ctl (.linkClk(linkClk), .chipSel_n(chipSel_n), .clkEnable(clkEnable),
		.cmd_addr_bus(cmd_addr_bus));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// The refusal pulse lasts one cycle, so latch it
	always @(posedge ref_clk) if (illegalCmd === 1'b1) sawIllegal = 1'b1;

	function automatic logic [12:0] rowOf(input logic [9:0] rr, input logic [9:0] ff);
		return {rr[6:2], ff[7:0]};
	endfunction : rowOf
	// Lowest column bit is never sent, so it is zero
	function automatic logic [7:0] colOf(input logic [9:0] rr, input logic [9:0] ff);
		return {ff[5:1], rr[6:5], 1'b0};
	endfunction : colOf
	function automatic logic [35:0] expBanks();
		return {expSt[3], expSt[2], expSt[1], expSt[0]};
	endfunction : expBanks
	task automatic check(input string what, input logic [51:0] exp, input logic [51:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Unmasked bits get random but defined levels; waits out every timer after
	task automatic go(input logic csn, input logic cke, input logic [9:0] pr, input logic [9:0] mr,
			input logic a);
		r = (10'($urandom) & ~mr) | (pr & mr);
		f = 10'($urandom);
		f[0] = a;
		@(posedge ref_clk) #1;
		ctl.cmd(csn, cke, r, f);
		repeat (20) @(posedge ref_clk);
		#1;
	endtask : go
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#100us;
		errors++;
		tally_and_finish();
	end

	initial begin
		rst_n = 1'b0;
		initDone = 1'b0;
		sawIllegal = 1'b0;
		errors = 0;
		checks_done = 0;
		foreach (expSt[i]) expSt[i] = BK_IDLE;
		void'($urandom(32'hbee9));
		repeat (20) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		check("power-on", DV_POWER_ON, devState);
		check("banks", expBanks(), bankStates);
		// Enable seen high once first: the previous edge level is low after reset
		go(1'b1, 1'b1, 10'h000, 10'h000, 1'b0);
		check("still power-on", DV_POWER_ON, devState);
		// Reset command, then resetting power-down left before and after init
		go(1'b0, 1'b1, 10'h000, 10'h00f, 1'b0);
		check("resetting", DV_RESETTING, devState);
		for (int k = 0; k < 2; k++) begin
			go(1'b1, 1'b0, 10'h000, 10'h000, 1'b0);
			check("reset powerdown", DV_RESET_DOWN, devState);
			go(1'b1, 1'b1, 10'h000, 10'h000, 1'b0);
			check("reset powerdown exit", k ? DV_NORMAL : DV_RESETTING, devState);
			initDone = 1'b1;
		end
		// Random traffic over the four banks, auto-close and idle precharge mixed in
		for (int i = 0; i < 16; i++) begin
			b = 2'($urandom);
			if (expSt[b] == BK_IDLE) begin
				go(1'b0, 1'b1, {1'b0, b, 7'h02}, 10'h183, 1'b0);
				expSt[b] = BK_ACTIVE;
				check("row", rowOf(r, f), openRows[b * 13 +: 13]);
			end
			op = $urandom_range(1) ? 4'h5 : 4'h1;
			ap = 1'($urandom);
			go(1'b0, 1'b1, {1'b0, b, 3'h0, op}, 10'h187, ap);
			check("bank", b, lastBank);
			check("column", colOf(r, f), lastColumn);
			check("command", op[2] ? CM_READ : CM_WRITE, lastCmd);
			expSt[b] = ap ? BK_IDLE : BK_ACTIVE;
			if ($urandom_range(1)) begin
				go(1'b0, 1'b1, {1'b0, b, 7'h0b}, 10'h19f, 1'b0);
				expSt[b] = BK_IDLE;
			end
			check("banks", expBanks(), bankStates);
		end
		// Enable falling with select low and no sleep code, then a stray burst stop
		for (int k = 0; k < 2; k++) begin
			sawIllegal = 1'b0;
			go(1'b0, 1'(k), k ? 10'h003 : 10'h000, 10'h00f, 1'b0);
			check("refused", 1'b1, sawIllegal);
			check("unchanged", expBanks(), bankStates);
			check("device kept", DV_NORMAL, devState);
			if (k == 0) go(1'b1, 1'b1, 10'h000, 10'h000, 1'b0);
		end
		// Active power-down held with random select, then left
		go(1'b0, 1'b1, 10'h01b, 10'h01f, 1'b0);
		foreach (expSt[i]) expSt[i] = BK_IDLE;
		go(1'b0, 1'b1, 10'h082, 10'h183, 1'b0);
		expSt[1] = BK_ACTIVE;
		go(1'b1, 1'b0, 10'h000, 10'h000, 1'b0);
		check("active powerdown", DV_POWER_DOWN, devState);
		go(1'($urandom), 1'b0, 10'h000, 10'h000, 1'b0);
		check("powerdown hold", DV_POWER_DOWN, devState);
		go(1'b1, 1'b1, 10'h000, 10'h000, 1'b0);
		check("powerdown exit", DV_NORMAL, devState);
		check("banks", expBanks(), bankStates);
		go(1'b0, 1'b1, 10'h007, 10'h007, 1'b0);
		go(1'b0, 1'b1, 10'h01b, 10'h01f, 1'b0);
		// Refresh, mode read and mode write all return to normal
		for (int k = 0; k < 3; k++) begin
			go(1'b0, 1'b1, (k == 0) ? 10'h00c : ((k == 1) ? 10'h008 : 10'h000), 10'h00f, 1'b0);
			check("back to idle", DV_NORMAL, devState);
		end
		// Self refresh, then deepest sleep, each woken with no link edge
		for (int k = 0; k < 2; k++) begin
			go(1'b0, 1'b0, k ? 10'h003 : 10'h004, 10'h007, 1'b0);
			check("sleep", k ? DV_DEEPEST_SLEEP : DV_SELF_REFRESH, devState);
			ctl.setCke(1'b1);
			repeat (10) @(posedge ref_clk);
			#1;
			check("wake", k ? DV_POWER_ON : DV_NORMAL, devState);
			go(1'b1, 1'b1, 10'h000, 10'h000, 1'b0);
			check("after wake", k ? DV_POWER_ON : DV_NORMAL, devState);
		end
		tally_and_finish();
	end
endmodule : tb
